// File: rtl/dca_alu_slice.sv
// operand selection and arithmetic slice of the DSP core
//
// Summary of operation
// - square uses same register, W4..W7 only
// - multiply accepts six distinct W4..W7 pairs
// - sixteen working registers, four-bit index
// - implicit working operand is register zero
// - X prefetch from W8/W9, modify, indexed
// - Y prefetch from W10/W11, modify, indexed
// - prefetched data lands in W4..W7
// - accumulator add shifted word, acc flags only
// - add and carry-add set C,DC,N,OV,Z
// - file forms write file or default register
// - single shift keeps sign, LSB to carry
// - multi-bit shift updates only N and Z
// - branch one cycle, two when taken
// - status word holds C,DC,N,OV,sticky Z
// - per-accumulator overflow and saturation flags
`timescale 1ns/1ps
module dca_alu_slice
	import dca_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          rst_b,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic          wr_en,
	input  wire logic          rd_en,
	output logic      [DW-1:0] rd_data_q
);
	logic [DW-1:0]  w_q [NUM_W];
	logic [DW-1:0]  mem_q [MEM_WORDS];
	logic [DW-1:0]  cmd0_q, cmd1_q, cmd2_q;
	logic           c_q, z_q, ov_q, n_q, dc_q;
	logic           oa_q, ob_q, sa_q, sb_q;
	logic [ACW-1:0] acca_q, accb_q;
	dca_st_e        st_q;
	logic           taken_q, ill_q;
	logic [1:0]     cyc_q;

	logic [3:0]     op;
	logic [3:0]     wb_i, ws_i, wd_i;
	logic [LIT_W-1:0] lit;
	logic [1:0]     src;
	logic           carry_en, fdst, acc_b_sel;
	logic [MEM_IDX_W-1:0] f_idx;
	logic [DW-1:0]  f_val, opb;
	logic           go;

	logic [DW-1:0]  add_a, add_b, add_sum;
	logic           add_cin, add_c, add_dc, add_ov;
	logic           x_en, x_upd, x_sel, y_en, y_upd, y_sel;
	logic [DW-1:0]  x_addr, x_val, y_addr, y_val;

	logic           res_we, mem_we;
	logic [3:0]     res_idx;
	logic [DW-1:0]  res_val;
	logic           up_c, up_dc, up_n, up_ov, up_z;
	logic           nc, ndc, nn, nov, nz;
	logic           acc_we, acc_fl, noa, sa_set, pf_en, taken_d, ill_d;
	logic [ACW-1:0] acc_val;

	function automatic logic is_zero(input logic [DW-1:0] v);
		return v == '0;
	endfunction

	function automatic logic [DW-1:0] asr_fn(input logic [DW-1:0] v,
		input logic [LIT5_W-1:0] cnt);
		return DW'($signed(v) >>> cnt);
	endfunction

	// overflow into the guard bits: guard bits and bit 31 disagree
	function automatic logic acc_ovf(input logic [ACW-1:0] v);
		return !(&v[ACW-1:ACC_OA_LSB]) && (|v[ACW-1:ACC_OA_LSB]);
	endfunction

	function automatic logic [DW-1:0] mem_word(input logic [DW-1:0] a);
		return mem_q[a[MEM_IDX_LSB +: MEM_IDX_W]];
	endfunction

	function automatic logic cond_true(input logic [4:0] cc);
		logic r;
		r = 1'b0;
		unique case (cc)
			BC_C:   r = c_q;
			BC_GE:  r = n_q == ov_q;
			BC_GEU: r = c_q;
			BC_GT:  r = !z_q && (n_q == ov_q);
			BC_GTU: r = c_q && !z_q;
			BC_LE:  r = z_q || (n_q != ov_q);
			BC_LEU: r = !c_q || z_q;
			BC_LT:  r = n_q != ov_q;
			BC_LTU: r = !c_q;
			BC_N:   r = n_q;
			BC_NC:  r = !c_q;
			BC_NN:  r = !n_q;
			BC_NOV: r = !ov_q;
			BC_NZ:  r = !z_q;
			BC_OA:  r = oa_q;
			BC_OB:  r = ob_q;
			BC_OV:  r = ov_q;
			BC_SA:  r = sa_q;
			BC_SB:  r = sb_q;
			BC_AL:  r = 1'b1;
			BC_Z:   r = z_q;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	assign op        = cmd0_q[F_OP +: F_OP_W];
	assign wb_i      = cmd0_q[F_WB +: REG_IDX_W];
	assign ws_i      = cmd0_q[F_WS +: REG_IDX_W];
	assign wd_i      = cmd0_q[F_WD +: REG_IDX_W];
	assign lit       = cmd1_q[F_LIT +: LIT_W];
	assign src       = cmd1_q[F_SRC +: F_SRC_W];
	assign carry_en  = cmd1_q[F_CARRY];
	assign fdst      = cmd1_q[F_FDST];
	assign acc_b_sel = cmd2_q[F_ACC];
	assign f_idx     = lit[MEM_IDX_LSB +: MEM_IDX_W];
	assign f_val     = mem_q[f_idx];
	// a taken branch stalls one cycle; a start during it is dropped
	assign go = wr_en && (addr == ADR_GO) && (st_q == DCA_IDLE);

	always_comb
	begin
		unique case (src)
			SRC_LIT5:  opb = DW'(lit[LIT5_W-1:0]);
			SRC_LIT10: opb = DW'(lit);
			default:   opb = w_q[ws_i];
		endcase
	end

	assign add_a   = (op == OP_ADDF) ? f_val
		: ((src == SRC_LIT10) ? w_q[wd_i] : w_q[wb_i]);
	assign add_b   = (op == OP_ADDF) ? w_q[W_DEF] : opb;
	assign add_cin = carry_en & c_q;

	dca_adder u_add (
		.a     (add_a),
		.b     (add_b),
		.cin   (add_cin),
		.sum   (add_sum),
		.cout  (add_c),
		.dcout (add_dc),
		.ovf   (add_ov)
	);

	dca_agu u_xagu (
		.mode    (cmd2_q[F_XM +: F_PFM_W]),
		.base0   (w_q[W_XA0]),
		.base1   (w_q[W_XA1]),
		.index   (w_q[W_IDX]),
		.en      (x_en),
		.addr    (x_addr),
		.upd     (x_upd),
		.upd_sel (x_sel),
		.upd_val (x_val)
	);

	dca_agu u_yagu (
		.mode    (cmd2_q[F_YM +: F_PFM_W]),
		.base0   (w_q[W_YA0]),
		.base1   (w_q[W_YA1]),
		.index   (w_q[W_IDX]),
		.en      (y_en),
		.addr    (y_addr),
		.upd     (y_upd),
		.upd_sel (y_sel),
		.upd_val (y_val)
	);

	always_comb
	begin
		logic [DW-1:0]     v, m1, m2;
		logic [ACW-1:0]    wext, wsh, cur;
		logic [ACW:0]      s41;
		logic [SLIT4_W-1:0] sh;
		logic [2:0]        ps;
		logic [1:0]        o1, o2;
		logic [2*DW-1:0]   prod;
		v = '0; m1 = '0; m2 = '0; wext = '0; wsh = '0; s41 = '0;
		sh = '0; ps = '0; o1 = '0; o2 = '0; prod = '0;
		cur = acc_b_sel ? accb_q : acca_q;
		res_we = 1'b0; res_idx = wd_i; res_val = '0; mem_we = 1'b0;
		up_c = 1'b0; up_dc = 1'b0; up_n = 1'b0; up_ov = 1'b0; up_z = 1'b0;
		nc = 1'b0; ndc = 1'b0; nn = 1'b0; nov = 1'b0; nz = 1'b0;
		acc_we = 1'b0; acc_fl = 1'b0; acc_val = '0; noa = 1'b0;
		sa_set = 1'b0; pf_en = 1'b0; taken_d = 1'b0; ill_d = 1'b0;
		// flags that an operation does not name stay untouched
		unique case (op)
			OP_NOP: ;
			OP_ADD, OP_ADDF:
			begin
				res_val = add_sum;
				if (op == OP_ADDF && fdst)
					mem_we = 1'b1;
				else
				begin
					res_we = 1'b1;
					res_idx = (op == OP_ADDF) ? W_DEF : wd_i;
				end
				{up_c, up_dc, up_n, up_ov, up_z} = '1;
				nc = add_c;
				ndc = add_dc;
				nn = add_sum[DW-1];
				nov = add_ov;
				// the carry form can only clear zero, never set it
				nz = carry_en ? (z_q & is_zero(add_sum))
					: is_zero(add_sum);
			end
			OP_ASR1, OP_ASRF:
			begin
				v = (op == OP_ASRF) ? f_val : w_q[ws_i];
				res_val = asr_fn(v, LIT5_W'(1));
				if (op == OP_ASRF && fdst)
					mem_we = 1'b1;
				else
				begin
					res_we = 1'b1;
					res_idx = (op == OP_ASRF) ? W_DEF : wd_i;
				end
				{up_c, up_n, up_ov, up_z} = '1;
				nc = v[0];
				nn = res_val[DW-1];
				nz = is_zero(res_val);
			end
			OP_ASRN:
			begin
				res_we = 1'b1;
				res_val = asr_fn(w_q[wb_i], (src == SRC_LIT5)
					? lit[LIT5_W-1:0] : w_q[ws_i][LIT5_W-1:0]);
				{up_n, up_z} = '1;
				nn = res_val[DW-1];
				nz = is_zero(res_val);
			end
			OP_ACCADD:
			begin
				v = w_q[ws_i];
				wext = {{ACC_U_W{v[DW-1]}}, v, {DW{1'b0}}};
				sh = lit[SLIT4_W-1:0];
				// positive shift scales down, negative scales up
				wsh = sh[SLIT4_W-1] ? (wext << SLIT4_W'(-sh))
					: ACW'($signed(wext) >>> sh);
				s41 = {cur[ACW-1], cur} + {wsh[ACW-1], wsh};
				sa_set = s41[ACW] != s41[ACW-1];
				acc_val = sa_set ? (s41[ACW] ? ACC_MIN : ACC_MAX)
					: s41[ACW-1:0];
				acc_we = 1'b1;
				acc_fl = 1'b1;
				noa = acc_ovf(acc_val);
			end
			OP_MPY, OP_SQR:
			begin
				ps = cmd2_q[F_PAIR +: F_PAIR_W];
				if (op == OP_SQR)
				begin
					o1 = ps[1:0];
					o2 = ps[1:0];
				end
				else
				begin
					unique case (ps)
						3'h0: {o1, o2} = {2'h0, 2'h1};
						3'h1: {o1, o2} = {2'h0, 2'h2};
						3'h2: {o1, o2} = {2'h0, 2'h3};
						3'h3: {o1, o2} = {2'h1, 2'h2};
						3'h4: {o1, o2} = {2'h1, 2'h3};
						3'h5: {o1, o2} = {2'h2, 2'h3};
						default: ill_d = 1'b1;
					endcase
				end
				m1 = w_q[W_PF + REG_IDX_W'(o1)];
				m2 = w_q[W_PF + REG_IDX_W'(o2)];
				prod = $signed(m1) * $signed(m2);
				acc_val = ACW'($signed(prod));
				acc_we = !ill_d;
				pf_en = !ill_d;
			end
			OP_BRA:
				taken_d = cond_true(lit[LIT5_W-1:0]);
			default: ill_d = 1'b1;
		endcase
	end

	// working registers: bus, result, prefetch data and address update
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < NUM_W; i++)
				w_q[i] <= '0;
		end
		else if (wr_en && addr < ADR_STAT)
			w_q[addr[REG_IDX_W-1:0]] <= wr_data;
		else if (go)
		begin
			if (res_we)
				w_q[res_idx] <= res_val;
			if (pf_en && x_upd)
				w_q[x_sel ? W_XA1 : W_XA0] <= x_val;
			if (pf_en && y_upd)
				w_q[y_sel ? W_YA1 : W_YA0] <= y_val;
			if (pf_en && x_en)
				w_q[W_PF + REG_IDX_W'(cmd2_q[F_XD +: F_PFD_W])]
					<= mem_word(x_addr);
			// with equal destinations the Y word wins
			if (pf_en && y_en)
				w_q[W_PF + REG_IDX_W'(cmd2_q[F_YD +: F_PFD_W])]
					<= mem_word(y_addr);
		end
	end

	// data memory holds the file registers and the prefetch space
	always_ff @(posedge clk_sys)
	begin
		if (wr_en && addr >= ADR_MEM)
			mem_q[addr[MEM_IDX_W-1:0]] <= wr_data;
		else if (go && mem_we)
			mem_q[f_idx] <= res_val;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cmd0_q <= '0;
			cmd1_q <= '0;
			cmd2_q <= '0;
		end
		else if (wr_en)
		begin
			if (addr == ADR_CMD0)
				cmd0_q <= wr_data;
			if (addr == ADR_CMD1)
				cmd1_q <= wr_data;
			if (addr == ADR_CMD2)
				cmd2_q <= wr_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			{c_q, z_q, ov_q, n_q, dc_q} <= '0;
		else if (wr_en && addr == ADR_STAT)
		begin
			c_q <= wr_data[ST_C];
			z_q <= wr_data[ST_Z];
			ov_q <= wr_data[ST_OV];
			n_q <= wr_data[ST_N];
			dc_q <= wr_data[ST_DC];
		end
		else if (go)
		begin
			if (up_c)
				c_q <= nc;
			if (up_dc)
				dc_q <= ndc;
			if (up_n)
				n_q <= nn;
			if (up_ov)
				ov_q <= nov;
			if (up_z)
				z_q <= nz;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			acca_q <= '0;
			accb_q <= '0;
		end
		// a go is a bus write too; it must not shadow the result path
		else if (wr_en && addr != ADR_GO)
		begin
			unique case (addr)
				ADR_ACCA_L: acca_q[DW-1:0] <= wr_data;
				ADR_ACCA_H: acca_q[DW +: DW] <= wr_data;
				ADR_ACCA_U: acca_q[ACC_U_LSB +: ACC_U_W] <= wr_data[ACC_U_W-1:0];
				ADR_ACCB_L: accb_q[DW-1:0] <= wr_data;
				ADR_ACCB_H: accb_q[DW +: DW] <= wr_data;
				ADR_ACCB_U: accb_q[ACC_U_LSB +: ACC_U_W] <= wr_data[ACC_U_W-1:0];
				default: ;
			endcase
		end
		else if (go && acc_we)
		begin
			if (acc_b_sel)
				accb_q <= acc_val;
			else
				acca_q <= acc_val;
		end
	end

	// saturation is sticky; overflow follows each accumulator-add result, multiply and square leave it
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			{oa_q, ob_q, sa_q, sb_q} <= '0;
		else if (wr_en && addr == ADR_DSTAT)
		begin
			oa_q <= wr_data[DS_OA];
			ob_q <= wr_data[DS_OB];
			sa_q <= wr_data[DS_SA];
			sb_q <= wr_data[DS_SB];
		end
		else if (go && acc_fl)
		begin
			if (acc_b_sel)
			begin
				ob_q <= noa;
				sb_q <= sb_q | sa_set;
			end
			else
			begin
				oa_q <= noa;
				sa_q <= sa_q | sa_set;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			st_q <= DCA_IDLE;
		else
		begin
			unique case (st_q)
				DCA_IDLE:
					if (go && op == OP_BRA && taken_d)
						st_q <= DCA_STALL;
				DCA_STALL:
					st_q <= DCA_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			taken_q <= 1'b0;
			ill_q <= 1'b0;
			cyc_q <= CYC_BASE;
		end
		else if (go)
		begin
			taken_q <= taken_d;
			ill_q <= ill_d;
			cyc_q <= taken_d ? CYC_TAKEN : CYC_BASE;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			rd_data_q <= '0;
		else if (rd_en)
		begin
			rd_data_q <= '0;
			if (addr < ADR_STAT)
				rd_data_q <= w_q[addr[REG_IDX_W-1:0]];
			else if (addr >= ADR_MEM)
				rd_data_q <= mem_q[addr[MEM_IDX_W-1:0]];
			else
			begin
				unique case (addr)
					ADR_STAT:
					begin
						rd_data_q[ST_C] <= c_q;
						rd_data_q[ST_Z] <= z_q;
						rd_data_q[ST_OV] <= ov_q;
						rd_data_q[ST_N] <= n_q;
						rd_data_q[ST_DC] <= dc_q;
					end
					ADR_DSTAT:
					begin
						rd_data_q[DS_OA] <= oa_q;
						rd_data_q[DS_OB] <= ob_q;
						rd_data_q[DS_SA] <= sa_q;
						rd_data_q[DS_SB] <= sb_q;
					end
					ADR_CMD0: rd_data_q <= cmd0_q;
					ADR_CMD1: rd_data_q <= cmd1_q;
					ADR_CMD2: rd_data_q <= cmd2_q;
					ADR_GO:
					begin
						rd_data_q[GO_BUSY] <= st_q == DCA_STALL;
						rd_data_q[GO_TAKEN] <= taken_q;
						rd_data_q[GO_ILL] <= ill_q;
						rd_data_q[GO_CYC +: 2] <= cyc_q;
					end
					ADR_ACCA_L: rd_data_q <= acca_q[DW-1:0];
					ADR_ACCA_H: rd_data_q <= acca_q[DW +: DW];
					ADR_ACCA_U: rd_data_q <= DW'(acca_q[ACC_U_LSB +: ACC_U_W]);
					ADR_ACCB_L: rd_data_q <= accb_q[DW-1:0];
					ADR_ACCB_H: rd_data_q <= accb_q[DW +: DW];
					ADR_ACCB_U: rd_data_q <= DW'(accb_q[ACC_U_LSB +: ACC_U_W]);
					default: rd_data_q <= '0;
				endcase
			end
		end
	end
endmodule

// File: rtl/dca_pkg.sv
// constants, field layout and encodings for the operand and arithmetic slice
package dca_pkg;
	localparam int DW        = 16;
	localparam int AW        = 6;
	localparam int ACW       = 40;
	localparam int NUM_W     = 16;
	localparam int REG_IDX_W = 4;
	localparam int MEM_WORDS = 32;
	localparam int MEM_IDX_W = 5;
	localparam int MEM_IDX_LSB = 1;
	localparam int NIB_W     = 4;
	localparam int LIT_W     = 10;
	localparam int LIT5_W    = 5;
	localparam int SLIT4_W   = 4;
	localparam int ACC_U_LSB = 32;
	localparam int ACC_U_W   = 8;
	localparam int ACC_OA_LSB = 31;
	localparam logic [ACW-1:0] ACC_MAX = 40'h7F_FFFF_FFFF;
	localparam logic [ACW-1:0] ACC_MIN = 40'h80_0000_0000;

	// register map, word addresses on the plain port
	localparam logic [AW-1:0] ADR_STAT  = 6'h10;
	localparam logic [AW-1:0] ADR_DSTAT = 6'h11;
	localparam logic [AW-1:0] ADR_CMD0  = 6'h12;
	localparam logic [AW-1:0] ADR_CMD1  = 6'h13;
	localparam logic [AW-1:0] ADR_CMD2  = 6'h14;
	localparam logic [AW-1:0] ADR_GO    = 6'h15;
	localparam logic [AW-1:0] ADR_ACCA_L = 6'h16;
	localparam logic [AW-1:0] ADR_ACCA_H = 6'h17;
	localparam logic [AW-1:0] ADR_ACCA_U = 6'h18;
	localparam logic [AW-1:0] ADR_ACCB_L = 6'h19;
	localparam logic [AW-1:0] ADR_ACCB_H = 6'h1A;
	localparam logic [AW-1:0] ADR_ACCB_U = 6'h1B;
	localparam logic [AW-1:0] ADR_MEM   = 6'h20;

	// command fields
	localparam int F_OP = 0;
	localparam int F_OP_W = 4;
	localparam int F_WB = 4;
	localparam int F_WS = 8;
	localparam int F_WD = 12;
	localparam int F_LIT = 0;
	localparam int F_FDST = 12;
	localparam int F_SRC = 13;
	localparam int F_SRC_W = 2;
	localparam int F_CARRY = 15;
	localparam int F_XM = 0;
	localparam int F_YM = 4;
	localparam int F_PFM_W = 4;
	localparam int F_XD = 8;
	localparam int F_YD = 10;
	localparam int F_PFD_W = 2;
	localparam int F_PAIR = 12;
	localparam int F_PAIR_W = 3;
	localparam int F_ACC = 15;

	// status bit positions
	localparam int ST_C = 0;
	localparam int ST_Z = 1;
	localparam int ST_OV = 2;
	localparam int ST_N = 3;
	localparam int ST_DC = 8;
	localparam int DS_OA = 0;
	localparam int DS_OB = 1;
	localparam int DS_SA = 2;
	localparam int DS_SB = 3;
	localparam int GO_BUSY = 0;
	localparam int GO_TAKEN = 1;
	localparam int GO_ILL = 2;
	localparam int GO_CYC = 4;
	localparam logic [1:0] CYC_BASE  = 2'h1;
	localparam logic [1:0] CYC_TAKEN = 2'h2;

	// operations
	localparam logic [3:0] OP_NOP    = 4'h0;
	localparam logic [3:0] OP_ADD    = 4'h1;
	localparam logic [3:0] OP_ADDF   = 4'h2;
	localparam logic [3:0] OP_ASR1   = 4'h3;
	localparam logic [3:0] OP_ASRF   = 4'h4;
	localparam logic [3:0] OP_ASRN   = 4'h5;
	localparam logic [3:0] OP_ACCADD = 4'h6;
	localparam logic [3:0] OP_MPY    = 4'h7;
	localparam logic [3:0] OP_SQR    = 4'h8;
	localparam logic [3:0] OP_BRA    = 4'h9;
	localparam logic [1:0] SRC_WS    = 2'h0;
	localparam logic [1:0] SRC_LIT5  = 2'h1;
	localparam logic [1:0] SRC_LIT10 = 2'h2;

	// fixed working registers
	localparam logic [3:0] W_DEF = 4'h0;
	localparam logic [3:0] W_PF  = 4'h4;
	localparam logic [3:0] W_XA0 = 4'h8;
	localparam logic [3:0] W_XA1 = 4'h9;
	localparam logic [3:0] W_YA0 = 4'hA;
	localparam logic [3:0] W_YA1 = 4'hB;
	localparam logic [3:0] W_IDX = 4'hC;

	// prefetch mode kinds (mode[2:0]); mode[3] picks the second base
	localparam logic [2:0] PF_NONE = 3'h0;
	localparam logic [2:0] PF_PLAIN = 3'h1;
	localparam logic [2:0] PF_INC2 = 3'h2;
	localparam logic [2:0] PF_DEC2 = 3'h5;
	localparam logic [DW-1:0] PF_STEP = 16'h0002;
	localparam int NUM_PAIRS = 6;

	// branch conditions
	localparam logic [4:0] BC_C = 5'h00, BC_GE = 5'h01, BC_GEU = 5'h02;
	localparam logic [4:0] BC_GT = 5'h03, BC_GTU = 5'h04, BC_LE = 5'h05;
	localparam logic [4:0] BC_LEU = 5'h06, BC_LT = 5'h07, BC_LTU = 5'h08;
	localparam logic [4:0] BC_N = 5'h09, BC_NC = 5'h0A, BC_NN = 5'h0B;
	localparam logic [4:0] BC_NOV = 5'h0C, BC_NZ = 5'h0D, BC_OA = 5'h0E;
	localparam logic [4:0] BC_OB = 5'h0F, BC_OV = 5'h10, BC_SA = 5'h11;
	localparam logic [4:0] BC_SB = 5'h12, BC_AL = 5'h13, BC_Z = 5'h14;

	typedef enum logic {DCA_IDLE, DCA_STALL} dca_st_e;
endpackage

// File: rtl/dca_adder.sv
// 16-bit adder with carry, nibble carry and signed wrap outputs
`timescale 1ns/1ps
module dca_adder
	import dca_pkg::*;
(
	input  wire logic [DW-1:0] a,
	input  wire logic [DW-1:0] b,
	input  wire logic          cin,
	output logic      [DW-1:0] sum,
	output logic               cout,
	output logic               dcout,
	output logic               ovf
);
	logic [DW:0]    full;
	logic [NIB_W:0] low;

	assign full  = {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, cin};
	assign low   = {1'b0, a[NIB_W-1:0]} + {1'b0, b[NIB_W-1:0]}
		+ {{NIB_W{1'b0}}, cin};
	assign sum   = full[DW-1:0];
	assign cout  = full[DW];
	assign dcout = low[NIB_W];
	assign ovf   = (a[DW-1] == b[DW-1]) && (sum[DW-1] != a[DW-1]);
endmodule

// File: rtl/dca_agu.sv
// prefetch address generator: base, post-modify or indexed address
`timescale 1ns/1ps
module dca_agu
	import dca_pkg::*;
(
	input  wire logic [F_PFM_W-1:0] mode,
	input  wire logic [DW-1:0]      base0,
	input  wire logic [DW-1:0]      base1,
	input  wire logic [DW-1:0]      index,
	output logic                    en,
	output logic      [DW-1:0]      addr,
	output logic                    upd,
	output logic                    upd_sel,
	output logic      [DW-1:0]      upd_val
);
	logic [2:0]    kind;
	logic [DW-1:0] base;
	logic [DW-1:0] delta;

	assign kind    = mode[2:0];
	assign upd_sel = mode[F_PFM_W-1];
	assign base    = upd_sel ? base1 : base0;

	always_comb
	begin
		delta = '0;
		en = 1'b1;
		upd = 1'b0;
		addr = base;
		if (kind == PF_NONE)
		begin
			// only the second base has an indexed form; the first is "none"
			en = upd_sel;
			addr = base1 + index;
		end
		else if (kind >= PF_DEC2)
		begin
			upd = 1'b1;
			delta = DW'(PF_STEP * (kind - PF_DEC2 + 3'h1));
		end
		else if (kind >= PF_INC2)
		begin
			upd = 1'b1;
			delta = DW'(PF_STEP * (kind - PF_INC2 + 3'h1));
		end
		upd_val = (kind >= PF_DEC2) ? base - delta : base + delta;
	end
endmodule

// File: verification/dca_alu_slice_chk.sv
// port-level assertions for the operand and arithmetic slice
`timescale 1ns/1ps
module dca_alu_slice_chk
	import dca_pkg::*;
(
	input wire logic          clk_sys,
	input wire logic          rst_b,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wr_data,
	input wire logic          wr_en,
	input wire logic          rd_en,
	input wire logic [DW-1:0] rd_data_q
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence s_go;
		wr_en && addr == ADR_GO;
	endsequence
	sequence s_rd_go;
		rd_en && addr == ADR_GO;
	endsequence
	// a go right after another may be dropped, so demand an idle cycle first
	property p_go_cost;
		!(wr_en && addr == ADR_GO) ##1 s_go ##1 s_rd_go |=>
			rd_data_q[GO_BUSY] == rd_data_q[GO_TAKEN] &&
			(rd_data_q[GO_ILL] || rd_data_q[5:4] ==
			(rd_data_q[GO_TAKEN] ? CYC_TAKEN : CYC_BASE));
	endproperty
	property p_unmapped;
		rd_en && addr >= 6'h1C && addr <= 6'h1F |=> rd_data_q == 16'h0000;
	endproperty
	property p_hold;
		!rd_en |=> $stable(rd_data_q);
	endproperty
	property p_w_rw;
		wr_en && addr < 6'h10 ##1 rd_en && addr == $past(addr) |=>
			rd_data_q == $past(wr_data, 2);
	endproperty
	property p_acc_u;
		rd_en && (addr == ADR_ACCA_U || addr == ADR_ACCB_U) |=>
			rd_data_q[15:8] == 8'h00;
	endproperty
	property p_stat_rw;
		wr_en && addr == ADR_STAT ##1 rd_en && addr == ADR_STAT |=>
			rd_data_q[3:0] == $past(wr_data[3:0], 2) &&
			rd_data_q[ST_DC] == $past(wr_data[ST_DC], 2);
	endproperty
	property p_dstat_rw;
		wr_en && addr == ADR_DSTAT ##1 rd_en && addr == ADR_DSTAT |=>
			rd_data_q[3:0] == $past(wr_data[3:0], 2);
	endproperty
	property p_reset;
		$rose(rst_b) |-> rd_data_q == 16'h0000;
	endproperty

	a_go_cost: assert property (p_go_cost)
		else $error("branch cost or busy field wrong");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_hold: assert property (p_hold)
		else $error("read data moved without a read");
	a_w_rw: assert property (p_w_rw)
		else $error("working register readback wrong");
	a_acc_u: assert property (p_acc_u)
		else $error("accumulator upper byte padding wrong");
	a_stat_rw: assert property (p_stat_rw)
		else $error("status readback wrong");
	a_dstat_rw: assert property (p_dstat_rw)
		else $error("dsp status readback wrong");
	a_reset: assert property (p_reset)
		else $error("read data not cleared by reset");
endmodule

bind dca_alu_slice dca_alu_slice_chk i_chk (
	.clk_sys   (clk_sys),
	.rst_b     (rst_b),
	.addr      (addr),
	.wr_data   (wr_data),
	.wr_en     (wr_en),
	.rd_en     (rd_en),
	.rd_data_q (rd_data_q)
);

// File: verification/tb_top.sv
// self-checking bench for the operand and arithmetic slice
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	import dca_pkg::*;
	logic          clk_sys;
	logic          rst_b;
	logic [AW-1:0] addr;
	logic [DW-1:0] wr_data;
	logic          wr_en;
	logic          rd_en;
	logic [DW-1:0] rd_data_q;
	int            failures;
	int            n_tests;
	logic [DW-1:0] v [4:7];
	logic [3:0]    pa [6];
	logic [3:0]    pb [6];

	dca_alu_slice i_dca_alu_slice (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.addr      (addr),
		.wr_data   (wr_data),
		.wr_en     (wr_en),
		.rd_en     (rd_en),
		.rd_data_q (rd_data_q)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// strobe stays up until the next call, so calls run back to back
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		rd_en <= 1'b0;
	endtask

	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e,
		input logic [DW-1:0] m = 16'hFFFF);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		wr_en <= 1'b0;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		@(negedge clk_sys);
		`CHK(rd_data_q & m, e)
	endtask

	task automatic exec(input logic [DW-1:0] c0, c1, c2);
		wr(ADR_CMD0, c0);
		wr(ADR_CMD1, c1);
		wr(ADR_CMD2, c2);
		wr(ADR_GO, 16'h0000);
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		repeat (4000) @(posedge clk_sys);
		failures++;
		conclude();
	end

	initial
	begin
		rst_b = 1'b0;
		addr = '0;
		wr_data = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		v = '{16'h0002, 16'h0003, 16'h0005, 16'h0007};
		pa = '{4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6};
		pb = '{4'h5, 4'h6, 4'h7, 4'h6, 4'h7, 4'h7};
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(ADR_STAT, 16'h0000);
		for (int i = 0; i < NUM_W; i++)
		begin
			wr(6'(i), 16'h5A00 + 16'(i));
			rd(6'(i), 16'h5A00 + 16'(i));
		end
		wr(6'h1C, 16'hFFFF);
		rd(6'h1C, 16'h0000);
		wr(ADR_STAT, 16'h0000);
		wr(6'h01, 16'h7FFF);
		wr(6'h02, 16'h0001);
		exec(16'h3211, 16'h0000, 16'h0000);
		rd(6'h03, 16'h8000);
		rd(ADR_STAT, 16'h010C);
		wr(ADR_STAT, 16'h0003);
		wr(6'h01, 16'hFFFF);
		wr(6'h02, 16'h0000);
		exec(16'h3211, 16'h8000, 16'h0000);
		rd(6'h03, 16'h0000);
		rd(ADR_STAT, 16'h0103);
		wr(6'h00, 16'h0005);
		wr(ADR_MEM + 6'h02, 16'h0010);
		exec(16'h0002, 16'h1004, 16'h0000);
		rd(ADR_MEM + 6'h02, 16'h0015);
		rd(6'h00, 16'h0005);
		exec(16'h0002, 16'h0004, 16'h0000);
		rd(6'h00, 16'h001A);
		rd(ADR_MEM + 6'h02, 16'h0015);
		wr(ADR_STAT, 16'h0104);
		rd(ADR_STAT, 16'h0104);
		wr(6'h01, 16'h8003);
		exec(16'h3103, 16'h0000, 16'h0000);
		rd(6'h03, 16'hC001);
		rd(ADR_STAT, 16'h0109);
		wr(ADR_STAT, 16'h0005);
		wr(6'h01, 16'h8000);
		exec(16'h3015, 16'h2004, 16'h0000);
		rd(6'h03, 16'hF800);
		rd(ADR_STAT, 16'h000D);
		// literal form adds into the destination and clears all flags
		wr(6'h03, 16'h0010);
		exec(16'h3001, 16'h43FF, 16'h0000);
		rd(6'h03, 16'h040F);
		rd(ADR_STAT, 16'h0000);
		// shift count taken from a register
		wr(6'h02, 16'h0003);
		exec(16'h3215, 16'h0000, 16'h0000);
		rd(6'h03, 16'hF000);
		rd(ADR_STAT, 16'h0008);
		// single shift of a file register written back to the file
		exec(16'h0004, 16'h1004, 16'h0000);
		rd(ADR_MEM + 6'h02, 16'h000A);
		rd(ADR_STAT, 16'h0001);
		for (int w = 4; w < 8; w++)
			wr(6'(w), v[w]);
		for (int p = 0; p < 7; p++)
		begin
			exec(16'h0007, 16'h0000, {1'b0, 3'(p), 12'h000});
			if (p < NUM_PAIRS)
				rd(ADR_ACCA_L, v[pa[p]] * v[pb[p]]);
			else
				rd(ADR_GO, 16'h0004, 16'h0004);
		end
		for (int s = 4; s < 8; s++)
		begin
			exec(16'h0008, 16'h0000, {2'b00, 2'(s - 4), 12'h000});
			rd(ADR_ACCA_L, v[s] * v[s]);
		end
		exec(16'h000A, 16'h0000, 16'h0000);
		rd(ADR_GO, 16'h0004, 16'h0004);
		// post-modified X and Y fetch, then X indexed by the index register
		wr(ADR_MEM + 6'h02, 16'h1234);
		wr(ADR_MEM + 6'h04, 16'h5678);
		wr(ADR_MEM + 6'h05, 16'hBEEF);
		wr(6'h08, 16'h0004);
		wr(6'h0A, 16'h0008);
		exec(16'h0007, 16'h0000, 16'h0952);
		rd(6'h05, 16'h1234);
		rd(6'h06, 16'h5678);
		rd(6'h08, 16'h0006);
		rd(6'h0A, 16'h0006);
		wr(6'h09, 16'h0002);
		wr(6'h0C, 16'h0008);
		exec(16'h0007, 16'h0000, 16'h0308);
		rd(6'h07, 16'hBEEF);
		wr(ADR_ACCA_L, 16'h0000);
		wr(ADR_ACCA_H, 16'h0000);
		wr(ADR_ACCA_U, 16'h0000);
		wr(ADR_DSTAT, 16'h0000);
		rd(ADR_DSTAT, 16'h0000);
		wr(ADR_STAT, 16'h0001);
		wr(6'h01, 16'h0003);
		exec(16'h0106, 16'h0000, 16'h0000);
		rd(ADR_ACCA_H, 16'h0003);
		rd(ADR_ACCA_L, 16'h0000);
		rd(ADR_STAT, 16'h0001);
		wr(ADR_ACCB_L, 16'hFFFF);
		wr(ADR_ACCB_H, 16'hFFFF);
		wr(ADR_ACCB_U, 16'h007F);
		exec(16'h0106, 16'h0000, 16'h8000);
		rd(ADR_ACCB_U, 16'h007F);
		rd(ADR_DSTAT, 16'h000A);
		exec(16'h0009, 16'h0013, 16'h0000);
		rd(ADR_GO, 16'h0023);
		rd(ADR_GO, 16'h0022);
		exec(16'h0009, 16'h0014, 16'h0000);
		rd(ADR_GO, 16'h0010);
		rd(ADR_STAT, 16'h0001);
		conclude();
	end
endmodule
